/* File: verilog/pin_mux_consts.svh */
`ifndef PIN_MUX_CONSTS_SVH
`define PIN_MUX_CONSTS_SVH

`define PIN_DIRECTION_ADDR      12'h06E
`define INPUT_SELECT_BIT2_ADDR  12'h06F
`define INPUT_SELECT_BIT1_ADDR  12'h070
`define INPUT_SELECT_BIT0_ADDR  12'h071
`define OUTPUT_SELECT_BIT2_ADDR 12'h072
`define OUTPUT_SELECT_BIT1_ADDR 12'h073
`define OUTPUT_SELECT_BIT0_ADDR 12'h074
`define RESERVED_SLOT_ADDR      12'h075
`define PIN_OUTPUT_VALUES_ADDR  12'h076
`define PIN_INPUT_LEVELS_ADDR   12'h219

`define REG_RESET_VALUE         8'h00
`define SEL_GENERAL             3'h0
`define SEL_FUNC_A              3'h1
`define SEL_FUNC_B              3'h2
`define SEL_MANUAL_REF          3'h5

`define PIN_REF_SEL0_LOOP0      2
`define PIN_REF_SEL0_LOOP1      3
`define PIN_REF_SEL1_LOOP0      6
`define PIN_REF_SEL1_LOOP1      7
`define CLOCK_OUTPUT_ENABLE_PINS 8

`endif

/* File: verilog/pin_mux_pkg.sv */
package pin_mux_pkg;
  typedef logic [7:0]  byte_t;
  typedef logic [11:0] reg_addr_t;
  typedef logic [2:0]  sel_code_t;
endpackage : pin_mux_pkg

/* File: verilog/pin_output_slice.sv */
`timescale 1ns/10ps
`include "pin_mux_consts.svh"

module pin_output_slice (
  input  wire logic [2:0] out_sel_i,
  input  wire logic       out_value_i,
  input  wire logic       flag_a_i,
  input  wire logic       flag_b_i,
  output logic            pin_level_o
);
  // Reserved codes drive low rather than float
  always_comb begin
    unique case (out_sel_i)
      `SEL_GENERAL: pin_level_o = out_value_i;  // [R11] [R12]
      `SEL_FUNC_A:  pin_level_o = flag_a_i;     // [R13]
      `SEL_FUNC_B:  pin_level_o = flag_b_i;     // [R13]
      default:      pin_level_o = 1'b0;
    endcase
  end
endmodule : pin_output_slice

/* File: verilog/general_pin_function_mux.sv */
// Behaviour
// R1: Per-pin direction bit, 0 input, 1 output
// R2: Input selector 000 mirrors pin into status
// R3: Selector 001 on pins 0-4 gates clock outputs; code takes it on all 8 pins (0-7)
// R4: Pin 2 code 101 is loop0 select bit 0
// R5: Pin 3 code 101 is loop1 select bit 0
// R6: Software avoids reserved selector codes
// R7: Input levels readable at 0219h
// R8: Input selector bits sliced over 006F-0071
// R9: Output selector bits sliced over 0072-0074
// R10: Reserved bits written zero, read undefined
// R11: Output selector 000 drives output register bit
// R12: Output register resets 00h, shown in GP mode
// R13: Non-zero output selector drives a status flag; code only for 001 and 010, other codes drive low
// R14: Pins 6,7 code 101 are select bit 1
// R15: Input-mode pin is never driven
// R16: Reset leaves all pins general inputs
`timescale 1ns/10ps
`include "pin_mux_consts.svh"

module general_pin_function_mux (
  input  wire logic                   clock_i,
  input  wire logic                   rst_n_i,
  input  wire logic                   clk_en_i,
  input  wire pin_mux_pkg::reg_addr_t reg_addr_i,
  input  wire pin_mux_pkg::byte_t     reg_wdata_i,
  input  wire logic                   reg_write_i,
  input  wire logic                   reg_read_i,
  output pin_mux_pkg::byte_t          reg_rdata_o,
  input  wire pin_mux_pkg::byte_t     pin_i,
  output pin_mux_pkg::byte_t          pin_o,
  output pin_mux_pkg::byte_t          pin_oe_o,
  input  wire logic [1:0]             loss_of_lock_i,
  input  wire logic [1:0]             holdover_i,
  input  wire logic [3:0]             ref_loss_of_signal_i,
  output pin_mux_pkg::byte_t          clock_output_enable_o,
  output logic [1:0]                  loop0_manual_ref_select_o,
  output logic [1:0]                  loop1_manual_ref_select_o,
  output logic [1:0]                  loop0_manual_ref_valid_o,
  output logic [1:0]                  loop1_manual_ref_valid_o
);
  import pin_mux_pkg::*;

  byte_t     pin_direction_q, pin_direction_d;
  byte_t     in_sel2_q, in_sel2_d, in_sel1_q, in_sel1_d, in_sel0_q, in_sel0_d;
  byte_t     out_sel2_q, out_sel2_d, out_sel1_q, out_sel1_d, out_sel0_q, out_sel0_d;
  byte_t     pin_output_values_q, pin_output_values_d;
  byte_t     pin_input_levels_q, pin_input_levels_d;
  byte_t     reg_rdata_q, reg_rdata_d;
  byte_t     pin_q, pin_d;
  byte_t     pin_oe_q, pin_oe_d;
  byte_t     clk_oe_q, clk_oe_d;
  logic [1:0] l0_sel_q, l0_sel_d, l1_sel_q, l1_sel_d;
  logic [1:0] l0_val_q, l0_val_d, l1_val_q, l1_val_d;
  byte_t     slice_level;
  byte_t     flag_a, flag_b;

  function automatic sel_code_t in_sel(input int unsigned n);
    in_sel = {in_sel2_q[n], in_sel1_q[n], in_sel0_q[n]};  // [R8]
  endfunction : in_sel

  function automatic logic in_fn(input int unsigned n, input sel_code_t code);
    in_fn = !pin_direction_q[n] && (in_sel(n) == code);  // [R1]
  endfunction : in_fn

  // Status flag feeds per pin, codes 001 and 010
  always_comb begin
    flag_a = {ref_loss_of_signal_i[3], ref_loss_of_signal_i[2], ref_loss_of_signal_i[1],
              holdover_i[1], loss_of_lock_i[1], ref_loss_of_signal_i[0], holdover_i[0],
              loss_of_lock_i[0]};
    flag_b = {5'h00, 1'b0, holdover_i[1], loss_of_lock_i[1]};
    flag_b[3] = ref_loss_of_signal_i[1];
  end

  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : gen_out
      pin_output_slice u_slice (
        .out_sel_i   ({out_sel2_q[g], out_sel1_q[g], out_sel0_q[g]}),  // [R9]
        .out_value_i (pin_output_values_q[g]),
        .flag_a_i    (flag_a[g]),
        .flag_b_i    (flag_b[g]),
        .pin_level_o (slice_level[g])
      );
    end
  endgenerate

  // Register writes; reserved slot ignores data
  always_comb begin
    pin_direction_d     = pin_direction_q;
    in_sel2_d           = in_sel2_q;
    in_sel1_d           = in_sel1_q;
    in_sel0_d           = in_sel0_q;
    out_sel2_d          = out_sel2_q;
    out_sel1_d          = out_sel1_q;
    out_sel0_d          = out_sel0_q;
    pin_output_values_d = pin_output_values_q;
    if (reg_write_i) begin
      unique case (reg_addr_i)
        `PIN_DIRECTION_ADDR:      pin_direction_d     = reg_wdata_i;  // [R1]
        `INPUT_SELECT_BIT2_ADDR:  in_sel2_d           = reg_wdata_i;  // [R8]
        `INPUT_SELECT_BIT1_ADDR:  in_sel1_d           = reg_wdata_i;  // [R8]
        `INPUT_SELECT_BIT0_ADDR:  in_sel0_d           = reg_wdata_i;  // [R8]
        `OUTPUT_SELECT_BIT2_ADDR: out_sel2_d          = reg_wdata_i;  // [R9]
        `OUTPUT_SELECT_BIT1_ADDR: out_sel1_d          = reg_wdata_i;  // [R9]
        `OUTPUT_SELECT_BIT0_ADDR: out_sel0_d          = reg_wdata_i;  // [R9]
        `PIN_OUTPUT_VALUES_ADDR:  pin_output_values_d = reg_wdata_i;  // [R12]
        default: ;
      endcase
    end
  end

  // Readback one cycle after the read strobe; unmapped and reserved read zero [R10]
  always_comb begin
    reg_rdata_d = reg_rdata_q;
    if (reg_read_i) begin
      unique case (reg_addr_i)
        `PIN_DIRECTION_ADDR:      reg_rdata_d = pin_direction_q;
        `INPUT_SELECT_BIT2_ADDR:  reg_rdata_d = in_sel2_q;
        `INPUT_SELECT_BIT1_ADDR:  reg_rdata_d = in_sel1_q;
        `INPUT_SELECT_BIT0_ADDR:  reg_rdata_d = in_sel0_q;
        `OUTPUT_SELECT_BIT2_ADDR: reg_rdata_d = out_sel2_q;
        `OUTPUT_SELECT_BIT1_ADDR: reg_rdata_d = out_sel1_q;
        `OUTPUT_SELECT_BIT0_ADDR: reg_rdata_d = out_sel0_q;
        `PIN_OUTPUT_VALUES_ADDR:  reg_rdata_d = pin_output_values_q;
        `PIN_INPUT_LEVELS_ADDR:   reg_rdata_d = pin_input_levels_q;  // [R7]
        default:                  reg_rdata_d = 8'h00;
      endcase
    end
  end

  // Pin functions
  always_comb begin
    pin_input_levels_d = pin_input_levels_q;
    clk_oe_d           = clk_oe_q;
    for (int n = 0; n < 8; n++) begin
      // Non-general inputs keep last sampled value in the status byte
      if (in_fn(n, `SEL_GENERAL)) pin_input_levels_d[n] = pin_i[n];  // [R2]
      // Output enables held when pin not in that function; reserved codes on pin 4 ignored [R6]
      if (n < `CLOCK_OUTPUT_ENABLE_PINS && in_fn(n, `SEL_FUNC_A)) clk_oe_d[n] = pin_i[n];  // [R3]
      pin_d[n]    = pin_direction_q[n] ? slice_level[n] : 1'b0;  // [R15]
      pin_oe_d[n] = pin_direction_q[n];                          // [R1] [R15]
    end
    l0_val_d = {in_fn(`PIN_REF_SEL1_LOOP0, `SEL_MANUAL_REF), in_fn(`PIN_REF_SEL0_LOOP0, `SEL_MANUAL_REF)};
    l1_val_d = {in_fn(`PIN_REF_SEL1_LOOP1, `SEL_MANUAL_REF), in_fn(`PIN_REF_SEL0_LOOP1, `SEL_MANUAL_REF)};
    l0_sel_d = l0_sel_q;
    l1_sel_d = l1_sel_q;
    if (l0_val_d[0]) l0_sel_d[0] = pin_i[`PIN_REF_SEL0_LOOP0];  // [R4]
    if (l1_val_d[0]) l1_sel_d[0] = pin_i[`PIN_REF_SEL0_LOOP1];  // [R5]
    if (l0_val_d[1]) l0_sel_d[1] = pin_i[`PIN_REF_SEL1_LOOP0];  // [R14]
    if (l1_val_d[1]) l1_sel_d[1] = pin_i[`PIN_REF_SEL1_LOOP1];  // [R14]
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      pin_direction_q     <= `REG_RESET_VALUE;  // [R16]
      in_sel2_q           <= `REG_RESET_VALUE;  // [R16]
      in_sel1_q           <= `REG_RESET_VALUE;
      in_sel0_q           <= `REG_RESET_VALUE;
      out_sel2_q          <= `REG_RESET_VALUE;
      out_sel1_q          <= `REG_RESET_VALUE;
      out_sel0_q          <= `REG_RESET_VALUE;
      pin_output_values_q <= `REG_RESET_VALUE;  // [R12]
      pin_input_levels_q  <= `REG_RESET_VALUE;
      reg_rdata_q         <= `REG_RESET_VALUE;
      pin_q               <= `REG_RESET_VALUE;
      pin_oe_q            <= `REG_RESET_VALUE;
      clk_oe_q            <= 8'hFF;
      l0_sel_q            <= 2'h0;
      l1_sel_q            <= 2'h0;
      l0_val_q            <= 2'h0;
      l1_val_q            <= 2'h0;
    end else if (clk_en_i) begin
      pin_direction_q     <= pin_direction_d;
      in_sel2_q           <= in_sel2_d;
      in_sel1_q           <= in_sel1_d;
      in_sel0_q           <= in_sel0_d;
      out_sel2_q          <= out_sel2_d;
      out_sel1_q          <= out_sel1_d;
      out_sel0_q          <= out_sel0_d;
      pin_output_values_q <= pin_output_values_d;
      pin_input_levels_q  <= pin_input_levels_d;
      reg_rdata_q         <= reg_rdata_d;
      pin_q               <= pin_d;
      pin_oe_q            <= pin_oe_d;
      clk_oe_q            <= clk_oe_d;
      l0_sel_q            <= l0_sel_d;
      l1_sel_q            <= l1_sel_d;
      l0_val_q            <= l0_val_d;
      l1_val_q            <= l1_val_d;
    end
  end

  assign reg_rdata_o               = reg_rdata_q;
  assign pin_o                     = pin_q;
  assign pin_oe_o                  = pin_oe_q;
  assign clock_output_enable_o     = clk_oe_q;
  assign loop0_manual_ref_select_o = l0_sel_q;
  assign loop1_manual_ref_select_o = l1_sel_q;
  assign loop0_manual_ref_valid_o  = l0_val_q;
  assign loop1_manual_ref_valid_o  = l1_val_q;
endmodule : general_pin_function_mux

/* File: sim/board_pins_model.sv */
`timescale 1ns/10ps
module board_pins_model (
  input  wire pin_mux_pkg::byte_t dev_level_i,
  input  wire pin_mux_pkg::byte_t dev_oe_i,
  input  wire pin_mux_pkg::byte_t board_level_i,
  output pin_mux_pkg::byte_t      pin_level_o
);
  import pin_mux_pkg::*;
  // Board lines stay driven by the board while the device lets go
  assign pin_level_o = (dev_oe_i & dev_level_i) | (~dev_oe_i & board_level_i);
endmodule : board_pins_model

/* File: sim/general_pin_function_mux_monitor.sv */
`timescale 1ns/10ps
module general_pin_function_mux_monitor (
  input wire logic                   clock_i,
  input wire logic                   rst_n_i,
  input wire logic                   clk_en_i,
  input wire pin_mux_pkg::reg_addr_t reg_addr_i,
  input wire pin_mux_pkg::byte_t     reg_wdata_i,
  input wire logic                   reg_write_i,
  input wire logic                   reg_read_i,
  input wire pin_mux_pkg::byte_t     reg_rdata_o,
  input wire pin_mux_pkg::byte_t     pin_i,
  input wire pin_mux_pkg::byte_t     pin_o,
  input wire pin_mux_pkg::byte_t     pin_oe_o,
  input wire pin_mux_pkg::byte_t     clock_output_enable_o,
  input wire logic [1:0]             loop0_manual_ref_select_o,
  input wire logic [1:0]             loop1_manual_ref_select_o,
  input wire logic [1:0]             loop0_manual_ref_valid_o,
  input wire logic [1:0]             loop1_manual_ref_valid_o
);
  import pin_mux_pkg::*;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  sequence en_then(v); clk_en_i ##1 v; endsequence
  sequence dir_wr; clk_en_i && reg_write_i && reg_addr_i == 12'h06E ##1 clk_en_i; endsequence
  reset_values_a: assert property ($rose(rst_n_i) |-> pin_oe_o == 8'h00 && clock_output_enable_o == 8'hFF)
    else $error("outputs not at reset values");
  dir_write_a: assert property (dir_wr |=> pin_oe_o == $past(reg_wdata_i, 2))
    else $error("output enables do not follow direction write");
  freeze_hold_a: assert property (!clk_en_i |=> $stable(pin_oe_o) && $stable(clock_output_enable_o))
    else $error("state moved while clock enable low");
  input_undriven_a: assert property ((pin_o & ~pin_oe_o) == 8'h00)
    else $error("input pin has drive value");
  rdata_hold_a: assert property (!(clk_en_i && reg_read_i) |=> $stable(reg_rdata_o))
    else $error("read data changed without read");
  rsvd_read_a: assert property (clk_en_i && reg_read_i && reg_addr_i == 12'h075 |=> reg_rdata_o == 8'h00)
    else $error("reserved slot read not zero");
  loop0_bit0_a: assert property (en_then(loop0_manual_ref_valid_o[0]) |-> loop0_manual_ref_select_o[0] == $past(pin_i[2]))
    else $error("loop0 select bit0 not from pin 2");
  loop1_bit0_a: assert property (en_then(loop1_manual_ref_valid_o[0]) |-> loop1_manual_ref_select_o[0] == $past(pin_i[3]))
    else $error("loop1 select bit0 not from pin 3");
  loop0_bit1_a: assert property (en_then(loop0_manual_ref_valid_o[1]) |-> loop0_manual_ref_select_o[1] == $past(pin_i[6]))
    else $error("loop0 select bit1 not from pin 6");
  loop1_bit1_a: assert property (en_then(loop1_manual_ref_valid_o[1]) |-> loop1_manual_ref_select_o[1] == $past(pin_i[7]))
    else $error("loop1 select bit1 not from pin 7");
endmodule : general_pin_function_mux_monitor
bind general_pin_function_mux general_pin_function_mux_monitor i_mon (.clock_i, .rst_n_i, .clk_en_i, .reg_addr_i,
  .reg_wdata_i, .reg_write_i, .reg_read_i, .reg_rdata_o, .pin_i, .pin_o, .pin_oe_o, .clock_output_enable_o,
  .loop0_manual_ref_select_o, .loop1_manual_ref_select_o, .loop0_manual_ref_valid_o, .loop1_manual_ref_valid_o);

/* File: sim/general_pin_function_mux_tb_top.sv */
`timescale 1ns/10ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin bad_count++; $display("ERROR %s expected %h seen %h", n, e, g); end end
module general_pin_function_mux_tb_top;
  import pin_mux_pkg::*;
  logic       clock_i = 0, rst_n_i = 0, clk_en_i = 1, reg_write_i = 0, reg_read_i = 0;
  reg_addr_t  reg_addr_i = 12'h000;
  byte_t      reg_wdata_i = 8'h00, reg_rdata_o, pin_i, pin_o, pin_oe_o, clock_output_enable_o, board_level = 8'h00;
  logic [1:0] loss_of_lock_i = 2'h0, holdover_i = 2'h0, loop0_manual_ref_select_o, loop1_manual_ref_select_o;
  logic [1:0] loop0_manual_ref_valid_o, loop1_manual_ref_valid_o;
  logic [3:0] ref_loss_of_signal_i = 4'h0;
  int         bad_count = 0, check_count = 0, cycles = 0;
  always #10 clock_i = ~clock_i;
  general_pin_function_mux i_general_pin_function_mux (.clock_i, .rst_n_i, .clk_en_i, .reg_addr_i, .reg_wdata_i,
    .reg_write_i, .reg_read_i, .reg_rdata_o, .pin_i, .pin_o, .pin_oe_o, .loss_of_lock_i, .holdover_i,
    .ref_loss_of_signal_i, .clock_output_enable_o, .loop0_manual_ref_select_o, .loop1_manual_ref_select_o,
    .loop0_manual_ref_valid_o, .loop1_manual_ref_valid_o);
  board_pins_model i_board_pins_model (.dev_level_i(pin_o), .dev_oe_i(pin_oe_o), .board_level_i(board_level),
    .pin_level_o(pin_i));
  task automatic wr(input reg_addr_t a, input byte_t d);
    @(posedge clock_i);
    #1 reg_addr_i = a;
    reg_wdata_i = d;
    reg_write_i = 1;
    @(posedge clock_i);
    #1 reg_write_i = 0;
  endtask : wr
  task automatic rd(input reg_addr_t a, input byte_t e);
    @(posedge clock_i);
    #1 reg_addr_i = a;
    reg_read_i = 1;
    @(posedge clock_i);
    #1 reg_read_i = 0;
    `CHK("read data", e, reg_rdata_o)
  endtask : rd
  // Three edges cover the two-cycle path from a write to the pins
  task automatic settle;
    repeat (3) @(posedge clock_i);
    #1;
  endtask : settle
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_of_test
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      end_of_test();
    end
  end
  initial begin
    repeat (16) @(posedge clock_i);
    #1 rst_n_i = 1;
    for (int a = 'h6E; a <= 'h76; a++) rd(reg_addr_t'(a), 8'h00);
    `CHK("reset enables", 8'h00, pin_oe_o)
    `CHK("reset clock enables", 8'hFF, clock_output_enable_o)
    $display("test reset done");
    wr(12'h076, 8'hA5);
    wr(12'h06E, 8'hFF);
    settle();
    `CHK("general drive", 8'hA5, pin_o)
    wr(12'h06E, 8'h0F);
    settle();
    `CHK("half drive", 8'h05, pin_o)
    clk_en_i = 0;
    wr(12'h06E, 8'h00);
    settle();
    `CHK("frozen enables", 8'h0F, pin_oe_o)
    clk_en_i = 1;
    wr(12'h074, 8'h01);
    loss_of_lock_i = 2'h1;
    settle();
    `CHK("flag drive", 1'b1, pin_o[0])
    wr(12'h073, 8'h08);
    ref_loss_of_signal_i = 4'h2;
    settle();
    `CHK("second flag drive", 1'b1, pin_o[3])
    wr(12'h073, 8'h00);
    rd(12'h074, 8'h01);
    $display("test outputs done");
    wr(12'h074, 8'h00);
    wr(12'h06E, 8'h00);
    board_level = 8'h3C;
    wr(12'h219, 8'h00);
    settle();
    rd(12'h219, 8'h3C);
    wr(12'h071, 8'h1F);
    board_level = 8'h15;
    settle();
    `CHK("clock enables", 8'hF5, clock_output_enable_o)
    rd(12'h071, 8'h1F);
    $display("test inputs done");
    wr(12'h071, 8'hCC);
    wr(12'h06F, 8'hCC);
    board_level = 8'h44;
    settle();
    `CHK("loop0 select", 2'b11, loop0_manual_ref_select_o)
    `CHK("loop1 select", 2'b00, loop1_manual_ref_select_o)
    `CHK("select valid", 4'hF, {loop0_manual_ref_valid_o, loop1_manual_ref_valid_o})
    board_level = 8'h88;
    settle();
    `CHK("loop selects", 4'h3, {loop0_manual_ref_select_o, loop1_manual_ref_select_o})
    wr(12'h075, 8'h00);
    rd(12'h075, 8'h00);
    $display("test selects done");
    end_of_test();
  end
endmodule : general_pin_function_mux_tb_top
